// *** bench/dee_cpu_model.sv ***
// Purpose: CPU side bus master for the data EEPROM controller.
// Assumes: Single AHB-Lite slave, so hready is the slave's hreadyout.
// Notes: Released write data is inverted so stale bytes never match.
module dee_cpu (
	input wire hclk,
	input wire hready,
	input wire [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [7:0] d, output logic [7:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata[7:0];
		hwdata <= ~hwdata;
	endtask
endmodule // dee_cpu

// *** bench/dee_ctrl_properties.sv ***
// Purpose: Port assertions for the data EEPROM write controller.
// Assumes: Bound to dee_ctrl; a single hclk domain.
// Notes: Program state is internal, so the bench judges it by reads.
module dee_chk (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire hready,
	input wire [1:0] htrans,
	input wire hreadyout,
	input wire [31:0] hrdata,
	input wire hresp,
	input wire wait_for_irq_instr,
	input wire halt_req,
	input wire irq_vector_fetch,
	input wire done_irq,
	input wire wait_state,
	input wire halt_state
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	bus_one_wait_a: assert property (hsel && hready && htrans[1] |=>
		!hreadyout ##1 hreadyout) else $error("bus wait state wrong");
	read_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("read data moved off a read");
	upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	halt_entry_a: assert property (halt_req |=> halt_state)
		else $error("halt not entered");
	halt_cause_a: assert property ($rose(halt_state) |-> $past(halt_req))
		else $error("halt without request");
	wait_exit_a: assert property (!wait_for_irq_instr |=> !wait_state)
		else $error("wait held without request");
	wait_cause_a: assert property ($rose(wait_state) |->
		$past(wait_for_irq_instr)) else $error("wait without request");
	irq_clear_a: assert property ($fell(done_irq) |->
		$past(irq_vector_fetch)) else $error("irq dropped without fetch");
	irq_hold_a: assert property (done_irq && !irq_vector_fetch |=> done_irq)
		else $error("pending irq lost");
	cover property ($rose(done_irq));
	cover property ($rose(wait_state));
	cover property ($rose(halt_state));
endmodule // dee_chk

bind dee_ctrl dee_chk chk_i (.hclk, .hresetn, .hsel, .hready, .htrans,
	.hreadyout, .hrdata, .hresp, .wait_for_irq_instr, .halt_req,
	.irq_vector_fetch, .done_irq, .wait_state, .halt_state);

// *** bench/dee_ctrl_test.sv ***
// Purpose: Self-checking bench of the data EEPROM write controller.
// Assumes: Cycle counts shortened to 4 and 20 for run time.
// Notes: Array is unknown after reset, so rows are written first.
module dee_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ER = 4;
	localparam int WR = 20;
	localparam logic [31:0] CTRL_STATUS_REG = 32'h0000002C;
	localparam logic [31:0] ROW = 32'h00000440;
	logic hclk, hresetn, wait_req, halt_req, vec_fetch;
	wire hsel, hwrite, hready, hresp, done_irq, wait_state, halt_state;
	wire [31:0] haddr, hwdata, hrdata;
	wire [1:0] htrans;
	wire [2:0] hsize;
	int failures, num_checks;
	logic [7:0] q;
	time t0;
	dee_ctrl #(.ERASE_CYCLES(16'h0004), .WRITE_CYCLES(16'h0014)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
		.wait_for_irq_instr(wait_req), .halt_req(halt_req),
		.irq_vector_fetch(vec_fetch), .done_irq(done_irq),
		.wait_state(wait_state), .halt_state(halt_state));
	dee_cpu cpu (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));
	task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("Error %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic rd(input logic [31:0] a, input logic [7:0] e, string m);
		cpu.xfer(1'b0, a, 8'h00, q);
		chk(q, e, m);
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		cpu.xfer(1'b1, a, d, q);
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_prog;
		wr(CTRL_STATUS_REG, 8'h06);
		rd(ROW, 8'h00, "read in write mode");
		wr(ROW, 8'hF3);
		wr(ROW, 8'h3F);
		wr(ROW + 32'h3C, 8'hA5);
		rd(ROW + 32'h3C, 8'h00, "latch hidden");
		wr(CTRL_STATUS_REG, 8'h07);
		t0 = $time;
		wait_req <= 1'b1;
		wr(CTRL_STATUS_REG, 8'h05);
		rd(CTRL_STATUS_REG, 8'h07, "busy status");
		chk({7'h00, wait_state}, 8'h00, "wait during cycle");
		while (done_irq !== 1'b1 && $time < t0 + 5000) @(posedge hclk);
		chk(8'(($time - t0) / 50), 8'(ER + WR), "cycle length");
		chk({7'h00, wait_state}, 8'h01, "wait after cycle");
		wait_req <= 1'b0;
		rd(CTRL_STATUS_REG, 8'h04, "cycle end");
		rd(ROW, 8'h33, "merged byte");
		rd(ROW + 32'h3C, 8'hA5, "last column");
		chk({7'h00, done_irq}, 8'h01, "irq pending");
		vec_fetch <= 1'b1;
		wait_req <= 1'b1;
		@(posedge hclk);
		vec_fetch <= 1'b0;
		@(posedge hclk);
		chk({7'h00, done_irq}, 8'h00, "irq cleared");
		chk({7'h00, wait_state}, 8'h01, "idle wait");
		wait_req <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({7'h00, wait_state}, 8'h00, "wait left");
		$display("test program done");
	endtask
	task automatic t_misc;
		wr(ROW, 8'h00);
		wr(CTRL_STATUS_REG, 8'h01);
		rd(CTRL_STATUS_REG, 8'h00, "start refused");
		rd(ROW, 8'h33, "write ignored");
		wr(CTRL_STATUS_REG, 8'h02);
		wr(ROW + 32'h04, 8'h11);
		wr(CTRL_STATUS_REG, 8'h03);
		halt_req <= 1'b1;
		repeat (2) @(posedge hclk);
		chk({7'h00, halt_state}, 8'h01, "halt entry");
		halt_req <= 1'b0;
		repeat (2) @(posedge hclk);
		rd(CTRL_STATUS_REG, 8'h02, "halt abandons");
		wr(CTRL_STATUS_REG, 8'h00);
		wr(CTRL_STATUS_REG, 8'h02);
		wr(ROW + 32'h04, 8'h3C);
		wr(CTRL_STATUS_REG, 8'h03);
		repeat (ER + WR + 2) @(posedge hclk);
		rd(ROW + 32'h04, 8'h3C, "latch cleared");
		chk({7'h00, done_irq}, 8'h00, "no irq when disabled");
		rd(32'h00000030, 8'h00, "unmapped read");
		$display("test misc done");
	endtask
	task automatic t_abort;
		wr(CTRL_STATUS_REG, 8'h06);
		wr(ROW + 32'h08, 8'h5A);
		wr(CTRL_STATUS_REG, 8'h07);
		wr(CTRL_STATUS_REG, 8'h06);
		rd(CTRL_STATUS_REG, 8'h06, "abort stops cycle");
		repeat (ER + WR) @(posedge hclk);
		chk({7'h00, done_irq}, 8'h00, "no irq after abort");
		wr(CTRL_STATUS_REG, 8'h07);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(CTRL_STATUS_REG, 8'h00, "reset mid cycle");
		chk({7'h00, done_irq}, 8'h00, "no irq after reset");
		$display("test abort done");
	endtask
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	initial begin
		hresetn = 1'b0;
		wait_req = 1'b0;
		halt_req = 1'b0;
		vec_fetch = 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(CTRL_STATUS_REG, 8'h00, "reset value");
		t_prog();
		t_misc();
		t_abort();
		final_report();
	end
	initial begin
		#100000;
		failures++;
		final_report();
	end
endmodule // dee_ctrl_test

// *** rtl/dee_ctrl.v ***
// Purpose: Data EEPROM write controller with an AHB-Lite register slave.
// Assumes: One clock hclk; CPU wait, halt and vector fetch on hclk.
// Notes: Every transfer takes one wait state; responses are always OKAY.
// Summary of operation
// (RQ1) With write mode clear, array reads return the addressed byte.
// (RQ2) With write mode set and idle, array writes fill one of 16 latches.
// (RQ3) Setting program writes all latched bytes to the array in one cycle.
// (RQ4) The row programmed comes from the last array write before start.
// (RQ5) Software keeps latched writes in one row; only low four bits differ.
// (RQ6) Cycle end clears program and write mode together; irq if enabled.
// (RQ7) The pending interrupt clears when the CPU fetches the vector.
// (RQ8) Latches clear only at cycle end and when write mode falls.
// (RQ9) A repeated write to a latch ANDs with the earlier data.
// (RQ10) Latch contents can never be read by the CPU.
// (RQ11) Wait request enters wait at once when idle, else after the cycle.
// (RQ12) Halt stops at once and abandons any programming in progress.
// (RQ13) Array reads with write mode set leave the data bus undriven; here they read zero.
// (RQ14) Array writes with write mode clear are ignored.
// (RQ15) A cycle cut short by reset or software leaves contents unsure.
// (RQ16) Control register resets to 00h; bits 7:3 read zero.
// (RQ17) Write mode clears by software only while program is clear.
// (RQ18) Program bit reads one exactly while a cycle runs.
// (RQ19) The whole erase and write cycle is timed inside the block.
// (RQ20) Cycle length and array window base are module parameters.
// (RQ21) Setting program while write mode is clear starts nothing.
`include "dee_map.vh"

module dee_ctrl #(
	parameter [`DEE_DEC_W-1:0] ARRAY_BASE = `DEE_ARRAY_BASE, // RQ20
	parameter [`DEE_CNT_W-1:0] ERASE_CYCLES = `DEE_ERASE_CYCLES, // RQ20
	parameter [`DEE_CNT_W-1:0] WRITE_CYCLES = `DEE_WRITE_CYCLES // RQ20
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	input wire wait_for_irq_instr,
	input wire halt_req,
	input wire irq_vector_fetch,
	output reg done_irq,
	output reg wait_state,
	output reg halt_state
);

	localparam CW = `DEE_CNT_W;
	localparam DW = `DEE_DATA_W;
	localparam AW = `DEE_ADDR_W;
	localparam NL = `DEE_LATCHES;

	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_ERASE = 5'h02;
	localparam [4:0] ST_WRITE = 5'h04;
	localparam [4:0] ST_WAIT = 5'h08;
	localparam [4:0] ST_HALT = 5'h10;

	localparam [CW-1:0] ERASE_LAST = ERASE_CYCLES - 1'b1;
	localparam [CW-1:0] WRITE_LAST = WRITE_CYCLES - 1'b1;
	localparam [CW-1:0] LATCH_COUNT = `DEE_LATCH_COUNT;

	function is_csr;
		input [`DEE_DEC_W-1:0] a;
		begin
			is_csr = (a == `DEE_CSR_OFF);
		end
	endfunction

	function is_array;
		input [`DEE_DEC_W-1:0] a;
		begin
			is_array = (a[`DEE_WIN_HI:`DEE_WIN_LO] ==
				ARRAY_BASE[`DEE_WIN_HI:`DEE_WIN_LO]);
		end
	endfunction

	// Address phase capture.
	reg ap_valid;
	reg ap_write;
	reg ap_csr;
	reg ap_array;
	reg [AW-1:0] ap_idx;

	// Control/status bits.
	reg done_irq_enable;
	reg write_mode_bit;
	reg prog_cycle_go;

	reg [4:0] state;
	reg [4:0] next_state;
	reg [CW-1:0] cnt;
	reg [CW-1:0] next_cnt;

	reg [DW-1:0] latch_data [0:NL-1];
	reg [NL-1:0] latch_vld;
	reg [`DEE_ROW_W-1:0] row;

	reg next_pgm;
	reg next_lat;

	wire accept;
	wire csr_wr;
	wire arr_wr;
	wire rd_done;
	wire prog_start;
	wire sw_abort;
	wire prog_end;
	wire latch_clear;
	wire staging;
	wire [`DEE_COL_W-1:0] col;
	wire [`DEE_COL_W-1:0] commit_col;
	wire commit_slot;
	wire mem_we;
	wire [DW-1:0] mem_rdata;
	wire [DW-1:0] wbyte;
	wire [7:0] csr_view;

	assign accept = hsel & hready & htrans[`DEE_HTRANS_ACT];
	assign csr_wr = ap_valid & ap_write & ap_csr;
	assign arr_wr = ap_valid & ap_write & ap_array;
	assign rd_done = ap_valid & ~ap_write;
	assign wbyte = hwdata[DW-1:0];
	assign col = ap_idx[`DEE_COL_W-1:0];

	// A start needs write mode already set; otherwise it is dropped.
	assign prog_start = csr_wr & wbyte[`DEE_BIT_GO] & write_mode_bit &
		~prog_cycle_go & ~halt_req; // RQ21
	// Clearing program mid-cycle abandons it; the row may be half done.
	assign sw_abort = csr_wr & ~wbyte[`DEE_BIT_GO] & prog_cycle_go; // RQ15
	assign prog_end = (state == ST_WRITE) & (cnt == WRITE_LAST) &
		~halt_req & ~sw_abort;
	assign staging = write_mode_bit & ~prog_cycle_go; // RQ14
	assign latch_clear = prog_end | (write_mode_bit & ~next_lat); // RQ8

	assign commit_col = cnt[`DEE_COL_W-1:0];
	assign commit_slot = (state == ST_WRITE) & (cnt < LATCH_COUNT);
	// Only bytes that were latched are written; others keep their value.
	assign mem_we = commit_slot & latch_vld[commit_col] & ~halt_req &
		~sw_abort; // RQ3

	// Bits 7:3 are tied to zero here rather than stored.
	assign csr_view = {5'h00, done_irq_enable, write_mode_bit,
		prog_cycle_go}; // RQ16

	dee_mem #(
		.AW(AW),
		.DW(DW)
	) u_mem (
		.hclk(hclk),
		.hresetn(hresetn),
		.we(mem_we),
		.waddr({row, commit_col}), // RQ4
		.wdata(latch_data[commit_col]),
		.raddr(haddr[`DEE_IDX_HI:`DEE_IDX_LO]),
		.rdata(mem_rdata)
	);

	// Bus slave: address phase taken, then one wait state, then the data.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_csr <= 1'b0;
			ap_array <= 1'b0;
			ap_idx <= {AW{1'b0}};
			hreadyout <= 1'b1;
			hresp <= `DEE_HRESP_OKAY;
		end else begin
			hresp <= `DEE_HRESP_OKAY;
			if (ap_valid) begin
				ap_valid <= 1'b0;
				hreadyout <= 1'b1;
			end else if (accept) begin
				ap_valid <= 1'b1;
				ap_write <= hwrite;
				ap_csr <= is_csr(haddr[`DEE_DEC_W-1:0]);
				ap_array <= is_array(haddr[`DEE_DEC_W-1:0]);
				ap_idx <= haddr[`DEE_IDX_HI:`DEE_IDX_LO];
				hreadyout <= 1'b0;
			end
		end
	end

	// Read data. Latches are never on this path, only the array and the control register.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= `DEE_WORD0;
		end else if (rd_done) begin // RQ10
			if (ap_csr) begin
				hrdata <= {24'h000000, csr_view}; // RQ16
			end else if (ap_array & ~write_mode_bit) begin
				hrdata <= {24'h000000, mem_rdata}; // RQ1
			end else begin
				// The bus cannot float, so an undriven read shows zero.
				hrdata <= `DEE_WORD0; // RQ13
			end
		end
	end

	// Next values of the control bits.
	always @* begin
		next_pgm = prog_cycle_go;
		if (halt_req | prog_end | sw_abort) begin
			next_pgm = 1'b0; // RQ6
		end else if (prog_start) begin
			next_pgm = 1'b1;
		end
		next_lat = write_mode_bit;
		if (prog_end) begin
			next_lat = 1'b0; // RQ6
		end else if (csr_wr) begin
			if (wbyte[`DEE_BIT_WMODE]) begin
				next_lat = 1'b1;
			end else if (!prog_cycle_go) begin
				next_lat = 1'b0; // RQ17
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_irq_enable <= 1'b0;
			write_mode_bit <= 1'b0;
			prog_cycle_go <= 1'b0;
		end else begin
			if (csr_wr) begin
				done_irq_enable <= wbyte[`DEE_BIT_IRQEN];
			end
			write_mode_bit <= next_lat;
			prog_cycle_go <= next_pgm; // RQ18
		end
	end

	// Programming sequencer: erase phase, then write phase with commit.
	always @* begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			ST_IDLE: begin
				if (halt_req) begin
					next_state = ST_HALT;
				end else if (prog_start) begin
					next_state = ST_ERASE;
					next_cnt = {CW{1'b0}};
				end else if (wait_for_irq_instr) begin
					next_state = ST_WAIT; // RQ11
				end
			end
			ST_ERASE: begin
				if (halt_req) begin
					next_state = ST_HALT; // RQ12
				end else if (sw_abort) begin
					next_state = ST_IDLE;
				end else if (cnt == ERASE_LAST) begin
					next_state = ST_WRITE; // RQ19
					next_cnt = {CW{1'b0}};
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			ST_WRITE: begin
				if (halt_req) begin
					next_state = ST_HALT; // RQ12
				end else if (sw_abort) begin
					next_state = ST_IDLE;
				end else if (prog_end) begin
					// A pending wait is entered only after the cycle.
					next_state = wait_for_irq_instr ? ST_WAIT :
						ST_IDLE; // RQ11
					next_cnt = {CW{1'b0}};
				end else begin
					next_cnt = cnt + 1'b1; // RQ19
				end
			end
			ST_WAIT: begin
				if (halt_req) begin
					next_state = ST_HALT;
				end else if (!wait_for_irq_instr) begin
					next_state = ST_IDLE;
				end
			end
			ST_HALT: begin
				if (!halt_req) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_cnt = {CW{1'b0}};
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
			cnt <= {CW{1'b0}};
			wait_state <= 1'b0;
			halt_state <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			wait_state <= (next_state == ST_WAIT); // RQ11
			halt_state <= (next_state == ST_HALT); // RQ12
		end
	end

	// Row latch follows the most recent staged write.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			row <= {`DEE_ROW_W{1'b0}};
		end else if (arr_wr & staging) begin
			row <= ap_idx[AW-1:`DEE_COL_W]; // RQ4
		end
	end

	// Data latches. Software must stay in one row between cycles, since
	// only the last row seen is used for all sixteen bytes.
	// One process owns every latch, so each has a single driver.
	integer li;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (li = 0; li < NL; li = li + 1) begin
				latch_data[li] <= `DEE_LATCH_CLR;
			end
			latch_vld <= {NL{1'b0}};
		end else if (latch_clear) begin
			for (li = 0; li < NL; li = li + 1) begin
				latch_data[li] <= `DEE_LATCH_CLR; // RQ8
			end
			latch_vld <= {NL{1'b0}};
		end else if (arr_wr & staging) begin // RQ2
			// The clear value is all ones, so AND also covers
			// the first write; repeats over-program.
			latch_data[col] <= latch_data[col] & wbyte; // RQ9
			latch_vld[col] <= 1'b1;
		end
	end
	// Writes with write mode clear fall through every branch above.

	// End-of-cycle interrupt; a new request wins over the vector fetch.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_irq <= 1'b0;
		end else if (prog_end & done_irq_enable) begin
			done_irq <= 1'b1; // RQ6
		end else if (irq_vector_fetch) begin
			done_irq <= 1'b0; // RQ7
		end
	end

endmodule // dee_ctrl

// *** rtl/dee_map.vh ***
// Purpose: Shared constants of the data EEPROM write controller.
// Assumes: Included by bare name from every design file of the block.
// Notes: Array offsets are byte addresses; one byte per 32-bit word.
`ifndef DEE_MAP_VH
`define DEE_MAP_VH

`define DEE_DEC_W 12
`define DEE_CSR_OFF 12'h02C
`define DEE_ARRAY_BASE 12'h400
`define DEE_WIN_HI 11
`define DEE_WIN_LO 10
`define DEE_IDX_HI 9
`define DEE_IDX_LO 2

`define DEE_CSR_RESET 8'h00
`define DEE_BIT_GO 0
`define DEE_BIT_WMODE 1
`define DEE_BIT_IRQEN 2

`define DEE_DATA_W 8
`define DEE_ADDR_W 8
`define DEE_COL_W 4
`define DEE_ROW_W 4
`define DEE_LATCHES 16
`define DEE_LATCH_COUNT 16'h0010
`define DEE_LATCH_CLR 8'hFF
`define DEE_CNT_W 16
`define DEE_ERASE_CYCLES 16'h0064
`define DEE_WRITE_CYCLES 16'h0064

`define DEE_HTRANS_ACT 1
`define DEE_HRESP_OKAY 1'h0
`define DEE_WORD0 32'h00000000

`endif

// *** rtl/dee_mem.v ***
// Purpose: Byte array of the data EEPROM with one write and one read port.
// Assumes: Single clock; write and read addresses from the controller.
// Notes: Read data come out of a register, one cycle after the address.
`include "dee_map.vh"

module dee_mem #(
	parameter AW = `DEE_ADDR_W,
	parameter DW = `DEE_DATA_W
) (
	input wire hclk,
	input wire hresetn,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [DW-1:0] wdata,
	input wire [AW-1:0] raddr,
	output reg [DW-1:0] rdata
);

	reg [DW-1:0] cells [0:(1<<AW)-1];

	// Cells have no reset, as a real array keeps its contents.
	always @(posedge hclk) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata <= {DW{1'b0}};
		end else begin
			rdata <= cells[raddr];
		end
	end

endmodule // dee_mem
